// *** core/rtc2_config_reg.sv ***
// Notes on behaviour
// - sixteen bit host read write register
// - master reset clears; software reset keeps
// - select bits pick 150, 125, 100 us
// - select zero gives 57 us timeout
// - flag error if transmitter late
// - staging on: received words held in buffer
// - good message: staged words burst out
// - staging off: words written as received
// - host may read and write staging buffer
// - load bit rising copies utility to counter
// - load bit clears itself after load unless a software reset comes in the cycle after the load write
`include "rtc2_map.svh"
`timescale 1ns/100ps
`default_nettype none
module rtc2_config_reg
  import rtc2_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  input  wire logic              soft_reset,
  input  wire logic              host_sel,
  input  wire logic              host_wr,
  input  wire logic [ADDR_W-1:0] host_addr,
  input  wire logic [15:0]       host_wdata,
  output logic [15:0]            host_rdata,
  input  wire logic [15:0]       timetag_utility,
  output logic                   timetag_load,
  output logic [15:0]            timetag_load_value,
  input  wire logic              rtrt_wait_start,
  input  wire logic              rtrt_tx_begin,
  output logic                   rtrt_timeout_err,
  input  wire logic              msg_start,
  input  wire logic              rx_word_valid,
  input  wire logic [15:0]       rx_word_data,
  input  wire logic              msg_end_ok,
  input  wire logic              msg_end_err,
  output logic                   mem_wr_en,
  output logic [4:0]             mem_wr_addr,
  output logic [15:0]            mem_wr_data,
  output logic [15:0]            config_out
);

  rtc2_state_t  s_q;
  rtc2_state_t  s_d;
  rtc2_stage_if sif ();

  rtc2_stage_buf #(
    .WORDS (`RTC2_STAGE_WORDS)
  ) u_stage (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .ce      (ce),
    .sif     (sif)
  );

  logic        cfg_hit;
  logic        stg_hit;
  logic        host_rd;
  logic [11:0] to_limit;
  logic [15:0] rd_mux;
  logic        stg_full;
  logic        burst_last;
  logic        to_expired;

  // named views of the register fields used by the receive and time tag load logic
  logic [1:0]  rtrt_timeout_select;
  logic        receive_staging_enable;
  logic        timetag_load_strobe;

  assign cfg_hit                = host_sel && (host_addr == ADDR_W'(`RTC2_CFG2_OFFSET));
  assign stg_hit                = host_sel && (host_addr[ADDR_W-1:5] == (ADDR_W-5)'(`RTC2_STAGE_BASE >> 5));
  assign host_rd                = host_sel && !host_wr;
  assign rtrt_timeout_select    = s_q.cfg[`RTC2_TMO_SEL_HI:`RTC2_TMO_SEL_LO];
  assign receive_staging_enable = s_q.cfg[`RTC2_STAGE_EN_BIT];
  assign timetag_load_strobe    = s_q.cfg[`RTC2_TT_LOAD_BIT];
  // words past the buffer depth are dropped rather than wrapping onto word zero
  assign stg_full               = s_q.stg_cnt >= 6'(`RTC2_STAGE_WORDS);
  assign burst_last             = {1'b0, s_q.burst_idx} == (s_q.stg_cnt - 6'h01);
  assign to_expired             = s_q.to_run && (s_q.to_cnt == 12'h000);

  always_comb begin
    unique case (rtrt_timeout_select)
      `RTC2_TMO_SEL_150: to_limit = 12'(`RTC2_TO_150_CYC);
      `RTC2_TMO_SEL_125: to_limit = 12'(`RTC2_TO_125_CYC);
      `RTC2_TMO_SEL_100: to_limit = 12'(`RTC2_TO_100_CYC);
      default:           to_limit = 12'(`RTC2_TO_57_CYC);
    endcase
  end

  // unmapped reads return zero so the host never sees a stale word
  always_comb begin
    if (cfg_hit) begin
      rd_mux = s_q.cfg;
    end else if (stg_hit) begin
      rd_mux = sif.hrd_data;
    end else begin
      rd_mux = 16'h0000;
    end
  end

  always_comb begin
    s_d          = s_q;
    s_d.to_err   = 1'b0;
    s_d.tt_load  = 1'b0;
    s_d.mem_we   = 1'b0;
    sif.wr_en    = 1'b0;
    sif.wr_idx   = s_q.stg_cnt[4:0];
    sif.wr_data  = rx_word_data;
    sif.brd_idx  = s_q.burst_idx;
    sif.hrd_idx  = host_addr[4:0];

    // host access to the register; lower bits are plain storage
    if (cfg_hit && host_wr) begin
      s_d.cfg = host_wdata;
      if (host_wdata[`RTC2_TT_LOAD_BIT] && !timetag_load_strobe) begin
        s_d.tt_load = 1'b1;
        s_d.tt_val  = timetag_utility;
      end
    end
    // unless a software reset falls in the cycle after the write, the load bit stands for one cycle and only a read in that cycle sees it set
    if (s_q.tt_load) begin
      s_d.cfg[`RTC2_TT_LOAD_BIT] = 1'b0;
    end
    if (host_rd) begin
      s_d.rdata = rd_mux;
    end

    // rt-rt receive no-response timer
    if (rtrt_wait_start) begin
      s_d.to_run = 1'b1;
      s_d.to_cnt = to_limit - 12'h001;
    end else if (s_q.to_run) begin
      if (rtrt_tx_begin) begin
        s_d.to_run = 1'b0;
      end else if (to_expired) begin
        s_d.to_run = 1'b0;
        s_d.to_err = 1'b1;
      end else begin
        s_d.to_cnt = s_q.to_cnt - 12'h001;
      end
    end

    // receive data path
    unique case (s_q.phase)
      RTC2_COLLECT: begin
        if (msg_start) begin
          s_d.stg_cnt = 6'h00;
        end else if (rx_word_valid && !stg_full) begin
          s_d.stg_cnt = s_q.stg_cnt + 6'h01;
          if (receive_staging_enable) begin
            sif.wr_en = 1'b1;
          end else begin
            s_d.mem_we   = 1'b1;
            s_d.mem_addr = s_q.stg_cnt[4:0];
            s_d.mem_data = rx_word_data;
          end
        end else if (msg_end_err) begin
          s_d.stg_cnt = 6'h00;
        end else if (msg_end_ok && receive_staging_enable && s_q.stg_cnt != 6'h00) begin
          s_d.phase     = RTC2_BURST;
          s_d.burst_idx = 5'h00;
        end
      end
      RTC2_BURST: begin
        // one word a cycle; receive inputs are ignored until the burst drains
        s_d.mem_we    = 1'b1;
        s_d.mem_addr  = s_q.burst_idx;
        s_d.mem_data  = sif.brd_data;
        s_d.burst_idx = s_q.burst_idx + 5'h01;
        if (burst_last) begin
          s_d.phase   = RTC2_COLLECT;
          s_d.stg_cnt = 6'h00;
        end
      end
    endcase

    // host writes to the staging buffer yield to arriving words
    if (stg_hit && host_wr && !sif.wr_en) begin
      sif.wr_en   = 1'b1;
      sif.wr_idx  = host_addr[4:0];
      sif.wr_data = host_wdata;
    end

    // software reset stops traffic but leaves the configuration alone
    if (soft_reset) begin
      s_d.to_run  = 1'b0;
      s_d.to_err  = 1'b0;
      s_d.mem_we  = 1'b0;
      s_d.stg_cnt = 6'h00;
      s_d.phase   = RTC2_COLLECT;
      s_d.cfg     = s_q.cfg;
      s_d.tt_load = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q       <= '0;
      s_q.cfg   <= `RTC2_CFG2_RESET;
      s_q.phase <= RTC2_COLLECT;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign host_rdata         = s_q.rdata;
  assign timetag_load       = s_q.tt_load;
  assign timetag_load_value = s_q.tt_val;
  assign rtrt_timeout_err   = s_q.to_err;
  assign mem_wr_en          = s_q.mem_we;
  assign mem_wr_addr        = s_q.mem_addr;
  assign mem_wr_data        = s_q.mem_data;
  assign config_out         = s_q.cfg;

endmodule
`default_nettype wire

// *** core/rtc2_map.svh ***
`ifndef RTC2_MAP_SVH
`define RTC2_MAP_SVH

`define RTC2_CFG2_OFFSET    16'h0001
`define RTC2_STAGE_BASE     16'h0040
`define RTC2_CFG2_RESET     16'h0000

`define RTC2_TMO_SEL_HI     15
`define RTC2_TMO_SEL_LO     14
`define RTC2_STAGE_EN_BIT   13
`define RTC2_TT_LOAD_BIT    12

`define RTC2_TMO_SEL_150    2'h3
`define RTC2_TMO_SEL_125    2'h2
`define RTC2_TMO_SEL_100    2'h1

`define RTC2_CLK_MHZ        20
`define RTC2_TO_150_US      150
`define RTC2_TO_125_US      125
`define RTC2_TO_100_US      100
`define RTC2_TO_57_US       57
`define RTC2_TO_150_CYC     (`RTC2_TO_150_US * `RTC2_CLK_MHZ)
`define RTC2_TO_125_CYC     (`RTC2_TO_125_US * `RTC2_CLK_MHZ)
`define RTC2_TO_100_CYC     (`RTC2_TO_100_US * `RTC2_CLK_MHZ)
`define RTC2_TO_57_CYC      (`RTC2_TO_57_US * `RTC2_CLK_MHZ)

`define RTC2_STAGE_WORDS    32

`endif

// *** core/rtc2_pkg.sv ***
package rtc2_pkg;

  typedef enum logic {
    RTC2_COLLECT,
    RTC2_BURST
  } rtc2_phase_t;

  typedef struct packed {
    logic [15:0] cfg;
    logic [11:0] to_cnt;
    logic        to_run;
    logic        to_err;
    logic        tt_load;
    logic [15:0] tt_val;
    logic        mem_we;
    logic [4:0]  mem_addr;
    logic [15:0] mem_data;
    logic [5:0]  stg_cnt;
    logic [4:0]  burst_idx;
    rtc2_phase_t phase;
    logic        msg_ok;
    logic [15:0] rdata;
  } rtc2_state_t;

endpackage

// *** core/rtc2_stage_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface rtc2_stage_if;
  logic        wr_en;
  logic [4:0]  wr_idx;
  logic [15:0] wr_data;
  logic [4:0]  brd_idx;
  logic [15:0] brd_data;
  logic [4:0]  hrd_idx;
  logic [15:0] hrd_data;

  modport owner (output wr_en, wr_idx, wr_data, brd_idx, hrd_idx, input brd_data, hrd_data);
  modport store (input wr_en, wr_idx, wr_data, brd_idx, hrd_idx, output brd_data, hrd_data);
endinterface
`default_nettype wire

// *** core/rtc2_stage_buf.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtc2_stage_buf
  import rtc2_pkg::*;
#(
  parameter int WORDS = 32
) (
  input  wire logic   ref_clk,
  input  wire logic   arst_n,
  input  wire logic   ce,
  rtc2_stage_if.store sif
);

  typedef struct packed {
    logic [WORDS-1:0][15:0] mem;
  } rtc2_buf_state_t;

  rtc2_buf_state_t s_q;
  rtc2_buf_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (sif.wr_en) begin
      s_d.mem[sif.wr_idx] = sif.wr_data;
    end
  end

  // reads are from flops, so both ports see stored data without extra latency
  assign sif.brd_data = s_q.mem[sif.brd_idx];
  assign sif.hrd_data = s_q.mem[sif.hrd_idx];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// *** verification/rtc2_cfg_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtc2_cfg_chk (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        ce,
  input wire logic        soft_reset,
  input wire logic        host_sel,
  input wire logic        host_wr,
  input wire logic [15:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic        timetag_load,
  input wire logic        rtrt_timeout_err,
  input wire logic        msg_start,
  input wire logic        rx_word_valid,
  input wire logic        mem_wr_en,
  input wire logic [15:0] config_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_cfg_wr;
    ce && !soft_reset && host_sel && host_wr && host_addr == 16'h0001;
  endsequence
  sequence s_load_wr;
    s_cfg_wr ##0 (host_wdata[12] && !config_out[12]);
  endsequence
  property p_cfg_wr; s_cfg_wr |=> config_out[15:13] == $past(host_wdata[15:13]); endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("cfg write lost");
  property p_load; s_load_wr |=> timetag_load ##1 !timetag_load; endproperty
  a_load: assert property (p_load) else $error("load pulse wrong");
  property p_clr; ce && timetag_load && !host_sel |=> !config_out[12]; endproperty
  a_clr: assert property (p_clr) else $error("load bit stuck");
  property p_tmo; rtrt_timeout_err |=> !rtrt_timeout_err; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout not a pulse");
  // staged words must never reach memory word by word
  property p_stage; ce && config_out[13] && rx_word_valid && !msg_start |=> !mem_wr_en; endproperty
  a_stage: assert property (p_stage) else $error("staged word leaked");
  property p_direct; ce && !soft_reset && !config_out[13] && rx_word_valid && !msg_start |=> mem_wr_en; endproperty
  a_direct: assert property (p_direct) else $error("direct write missing");
  property p_soft; soft_reset && !host_sel |=> $stable(config_out[15:13]); endproperty
  a_soft: assert property (p_soft) else $error("soft reset hit cfg");
  property p_hard_rst; disable iff (1'b0) !arst_n |-> config_out == 16'h0000; endproperty
  a_hard_rst: assert property (p_hard_rst) else $error("cfg not cleared");
endmodule
bind rtc2_config_reg rtc2_cfg_chk chk_i (.ref_clk, .arst_n, .ce, .soft_reset, .host_sel, .host_wr,
  .host_addr, .host_wdata, .timetag_load, .rtrt_timeout_err, .msg_start, .rx_word_valid, .mem_wr_en, .config_out);
`default_nettype wire

// *** verification/rtc2_host_bfm.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtc2_host_bfm (
  input  wire logic [15:0] host_rdata,
  input  wire logic        ref_clk,
  output logic             host_sel,
  output logic             host_wr,
  output logic [15:0]      host_addr,
  output logic [15:0]      host_wdata
);
  initial {host_sel, host_wr, host_addr, host_wdata} = '0;
  // callers flip staging enable only between messages, with ce still high
  task acc(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
    @(negedge ref_clk);
    {host_sel, host_wr, host_addr, host_wdata} = {1'b1, w, a, d};
    @(negedge ref_clk);
    q = host_rdata;
    // released bus shows inverted junk, not the old value
    {host_sel, host_addr, host_wdata} = {1'b0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// *** verification/rtc2_config_reg_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtc2_config_reg_tb;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b1;
  logic        ce_q = 1'b1;
  logic [6:0]  ev_q = 7'h00;
  logic [15:0] rx_d = 16'h0000;
  logic [15:0] tt_u = 16'h0000;
  logic        host_sel, host_wr, timetag_load, rtrt_timeout_err, mem_wr_en;
  logic [15:0] host_addr, host_wdata, host_rdata, tt_val, mem_wr_data, config_out, q, ld;
  logic [4:0]  mem_wr_addr, la;
  int          err_total = 0, comparisons = 0, nw = 0, nerr = 0, cyc = 0, n;
  int          lim[4] = '{1140, 2000, 2500, 3000};
  always #25 ref_clk = ~ref_clk;
  rtc2_config_reg rtc2_config_reg_i (.ref_clk, .arst_n, .ce(ce_q), .soft_reset(ev_q[0]), .host_sel, .host_wr,
    .host_addr, .host_wdata, .host_rdata, .timetag_utility(tt_u), .timetag_load, .timetag_load_value(tt_val),
    .rtrt_wait_start(ev_q[6]), .rtrt_tx_begin(ev_q[5]), .rtrt_timeout_err, .msg_start(ev_q[4]),
    .rx_word_valid(ev_q[3]), .rx_word_data(rx_d), .msg_end_ok(ev_q[2]), .msg_end_err(ev_q[1]),
    .mem_wr_en, .mem_wr_addr, .mem_wr_data, .config_out);
  rtc2_host_bfm rtc2_host_bfm_i (.host_rdata, .ref_clk, .host_sel, .host_wr, .host_addr, .host_wdata);
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ceiling well above the longest timeout sweep
  always @(negedge ref_clk) begin
    cyc++;
    if (mem_wr_en === 1'b1) begin
      nw++;
      la = mem_wr_addr;
      ld = mem_wr_data;
    end
    if (rtrt_timeout_err === 1'b1) nerr++;
    if (cyc == 40000) begin
      err_total++;
      results;
    end
  end
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    rtc2_host_bfm_i.acc(1'b1, a, d, q);
  endtask
  task rc(input string nm, input logic [15:0] a, input logic [15:0] e);
    rtc2_host_bfm_i.acc(1'b0, a, 16'h0000, q);
    chk(nm, q, e);
  endtask
  task ev(input logic [6:0] b);
    @(negedge ref_clk);
    ev_q = b;
    @(negedge ref_clk);
    ev_q = 7'h00;
  endtask
  task word(input logic [15:0] d);
    rx_d = d;
    ev(7'h08);
  endtask
  initial begin
    // a real falling edge, so the flops are cleared before the first clock edge
    #1 arst_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    arst_n = 1'b1;
    rc("cfg_rst", 16'h0001, 16'h0000);
    wr(16'h0001, 16'hE5A3);
    rc("cfg_rw", 16'h0001, 16'hE5A3);
    chk("cfg_out", config_out, 16'hE5A3);
    rc("unmapped", 16'h0002, 16'h0000);
    ev(7'h01);
    rc("cfg_soft", 16'h0001, 16'hE5A3);
    ce_q = 1'b0;
    wr(16'h0001, 16'h0000);
    ce_q = 1'b1;
    rc("ce_hold", 16'h0001, 16'hE5A3);
    wr(16'h0041, 16'hBEEF);
    rc("stage_host", 16'h0041, 16'hBEEF);
    tt_u = 16'h1234;
    wr(16'h0001, 16'h1000);
    chk("tt_load", {15'h0000, timetag_load}, 16'h0001);
    chk("tt_val", tt_val, 16'h1234);
    rc("tt_clear", 16'h0001, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      wr(16'h0001, 16'(s << 14));
      ev(7'h40);
      n = 0;
      while (rtrt_timeout_err !== 1'b1 && n < 4000) begin
        @(negedge ref_clk);
        n++;
      end
      chk("timeout", 16'(n), 16'(lim[s]));
    end
    ev(7'h40);
    repeat (10) @(negedge ref_clk);
    ev(7'h20);
    n = nerr;
    repeat (3100) @(negedge ref_clk);
    chk("tx_begun", 16'(nerr - n), 16'h0000);
    wr(16'h0001, 16'h0000);
    n = nw;
    ev(7'h10);
    word(16'hA001);
    word(16'hA002);
    ev(7'h04);
    chk("direct_cnt", 16'(nw - n), 16'h0002);
    chk("direct_dat", ld, 16'hA002);
    wr(16'h0001, 16'h2000);
    n = nw;
    ev(7'h10);
    word(16'hB001);
    word(16'hB002);
    ev(7'h04);
    chk("stage_hold", 16'(nw - n), 16'h0000);
    repeat (4) @(negedge ref_clk);
    chk("burst_cnt", 16'(nw - n), 16'h0002);
    chk("burst_addr", {11'h000, la}, 16'h0001);
    chk("burst_dat", ld, 16'hB002);
    n = nw;
    ev(7'h10);
    word(16'hC001);
    ev(7'h02);
    repeat (4) @(negedge ref_clk);
    chk("err_drop", 16'(nw - n), 16'h0000);
    arst_n = 1'b0;
    @(negedge ref_clk);
    arst_n = 1'b1;
    rc("cfg_mr", 16'h0001, 16'h0000);
    results;
  end
endmodule
`default_nettype wire
